// *** src/trig_pkg.sv ***
// Functional notes
// - Output trigger every divider plus one events.
// - Wait start-delay PWM cycles before first trigger.
// - Secondary generator never raises trigger interrupts.
// - Divider bits 15-12, delay 5-0, rest zero.
`default_nettype none
package trig_pkg;
    localparam int unsigned DIV_W        = 4;
    localparam int unsigned STRT_W       = 6;
    localparam int unsigned DIV_LSB      = 12;
    localparam int unsigned STRT_LSB     = 0;
    localparam logic [15:0] CTRL_MASK    = 16'hf03f;
    localparam logic [15:0] CTRL_RESET   = 16'h0000;
    // Byte addresses of the registers on the AXI4-Lite bus.
    localparam logic [3:0]  ADDR_CTRL    = 4'h0;
    localparam logic [3:0]  ADDR_ENABLE  = 4'h4;
    localparam logic [3:0]  ADDR_STATUS  = 4'h8;
    localparam logic [3:0]  ADDR_MASK    = 4'hc;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;
    // Status bits: output trigger fired, delay expired.
    localparam int unsigned STAT_W       = 2;
    localparam int unsigned STAT_TRIG    = 0;
    localparam int unsigned STAT_START   = 1;

    typedef struct packed {
        logic [DIV_W-1:0]  divider;
        logic [STRT_W-1:0] start_delay;
    } ctrl_t;
endpackage : trig_pkg
`default_nettype wire

// *** src/trig_delay.sv ***
`default_nettype none
// Counts whole PWM cycles after enable; ready rises when the count is met.
module trig_delay #(
    parameter int unsigned W = trig_pkg::STRT_W
) (
    // Clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // Control
    input  wire logic         enable,
    input  wire logic [W-1:0] delay,
    input  wire logic         pwm_cycle,
    // Result
    output logic              ready,
    output logic              done_pulse
);
    logic [W-1:0] count_q;
    logic         ready_q;
    wire          reached = (count_q >= delay);

    always_ff @(posedge aclk) begin
        if (!aresetn || !enable) begin
            count_q <= '0;
            ready_q <= 1'b0;
        end else if (!ready_q && reached) begin
            ready_q <= 1'b1;
        end else if (!ready_q && pwm_cycle) begin
            count_q <= count_q + 1'b1;
        end
    end

    assign ready      = ready_q;
    assign done_pulse = enable && !ready_q && reached;

    delay_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        enable && !ready_q && !reached |=> !ready_q)
        else $error("delay ended before its count");
endmodule : trig_delay
`default_nettype wire

// *** src/trig_divider.sv ***
`default_nettype none
// Passes one event out of every divider plus one.
module trig_divider #(
    parameter int unsigned W = trig_pkg::DIV_W
) (
    // Clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // Control
    input  wire logic         run,
    input  wire logic [W-1:0] divider,
    input  wire logic         event_in,
    // Result
    output logic              fire
);
    logic [W-1:0] count_q;
    wire          last = (count_q >= divider);

    always_ff @(posedge aclk) begin
        if (!aresetn || !run) begin
            count_q <= '0;
        end else if (event_in) begin
            count_q <= last ? '0 : count_q + 1'b1;
        end
    end

    assign fire = run && event_in && last;

    div_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
        run && event_in && divider == '0 |-> fire)
        else $error("divide by one dropped an event");
endmodule : trig_divider
`default_nettype wire

// *** src/pwm_trigger_postscaler.sv ***
// The register addresses and the AXI4-Lite interface to the registers were decided locally.
`default_nettype none
// Trigger postscaler for one PWM channel with an AXI4-Lite register port.
module pwm_trigger_postscaler (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // PWM time base, same clock
    input  wire logic        pwm_cycle,
    input  wire logic        trigger_event,
    input  wire logic        secondary,
    // Trigger outputs
    output logic             trigger_out,
    output logic             irq
);
    logic [15:0]                     ctrl_q;
    logic                            enable_q;
    logic [trig_pkg::STAT_W-1:0]     status_q;
    logic [trig_pkg::STAT_W-1:0]     mask_q;
    logic                            aw_held_q;
    logic [3:0]                      aw_addr_q;
    logic                            w_held_q;
    logic [31:0]                     w_data_q;
    logic [3:0]                      w_strb_q;
    logic                            trig_q;
    trig_pkg::ctrl_t                 cfg;
    logic                            delay_ready;
    logic                            delay_done;
    logic                            div_fire;

    assign cfg.divider     = ctrl_q[trig_pkg::DIV_LSB +: trig_pkg::DIV_W];
    assign cfg.start_delay = ctrl_q[trig_pkg::STRT_LSB +: trig_pkg::STRT_W];

    trig_delay #(.W(trig_pkg::STRT_W)) u_delay (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .enable     (enable_q),
        .delay      (cfg.start_delay),
        .pwm_cycle  (pwm_cycle),
        .ready      (delay_ready),
        .done_pulse (delay_done)
    );

    // The divider only sees events once the start delay has run out.
    trig_divider #(.W(trig_pkg::DIV_W)) u_div (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .run      (enable_q && delay_ready),
        .divider  (cfg.divider),
        .event_in (trigger_event),
        .fire     (div_fire)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trig_q <= 1'b0;
        end else begin
            trig_q <= div_fire;
        end
    end
    assign trigger_out = trig_q;

    // Write channel: address and data are captured independently.
    wire aw_take  = s_axi_awvalid && !aw_held_q;
    wire w_take   = s_axi_wvalid && !w_held_q;
    wire wr_go    = aw_held_q && w_held_q && !s_axi_bvalid;
    wire wr_ctrl  = wr_go && aw_addr_q == trig_pkg::ADDR_CTRL;
    wire wr_en    = wr_go && aw_addr_q == trig_pkg::ADDR_ENABLE;
    wire wr_stat  = wr_go && aw_addr_q == trig_pkg::ADDR_STATUS;
    wire wr_mask  = wr_go && aw_addr_q == trig_pkg::ADDR_MASK;
    wire wr_known = wr_ctrl || wr_en || wr_stat || wr_mask;

    assign s_axi_awready = !aw_held_q;
    assign s_axi_wready  = !w_held_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= 4'h0;
        end else if (aw_take) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_held_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else if (w_take) begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end else if (wr_go) begin
            w_held_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= trig_pkg::RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_known ? trig_pkg::RESP_OKAY : trig_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Byte lanes merge into the control word; unimplemented bits never store.
    wire [15:0] strb_bits = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
    wire [15:0] ctrl_new  = ((ctrl_q & ~strb_bits) | (w_data_q[15:0] & strb_bits)) & trig_pkg::CTRL_MASK;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q   <= trig_pkg::CTRL_RESET;
            enable_q <= 1'b0;
            mask_q   <= '0;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= ctrl_new;
            end
            if (wr_en && w_strb_q[0]) begin
                enable_q <= w_data_q[0];
            end
            if (wr_mask && w_strb_q[0]) begin
                mask_q <= w_data_q[trig_pkg::STAT_W-1:0];
            end
        end
    end

    // A new event wins over a write-one-to-clear in the same cycle.
    wire [trig_pkg::STAT_W-1:0] stat_set;
    wire [trig_pkg::STAT_W-1:0] stat_clr;
    assign stat_set[trig_pkg::STAT_TRIG]  = div_fire;
    assign stat_set[trig_pkg::STAT_START] = delay_done;
    assign stat_clr = (wr_stat && w_strb_q[0]) ? w_data_q[trig_pkg::STAT_W-1:0] : '0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_q <= '0;
        end else begin
            status_q <= (status_q & ~stat_clr) | stat_set;
        end
    end

    // A secondary generator keeps its status but never interrupts.
    assign irq = !secondary && |(status_q & mask_q);

    // Read channel.
    wire [31:0] rd_word =
        (s_axi_araddr == trig_pkg::ADDR_CTRL)   ? {16'h0000, ctrl_q & trig_pkg::CTRL_MASK} :
        (s_axi_araddr == trig_pkg::ADDR_ENABLE) ? {31'h0000_0000, enable_q} :
        (s_axi_araddr == trig_pkg::ADDR_STATUS) ? {30'h0000_0000, status_q} :
        (s_axi_araddr == trig_pkg::ADDR_MASK)   ? {30'h0000_0000, mask_q} : 32'h0000_0000;
    wire rd_known = s_axi_araddr == trig_pkg::ADDR_CTRL || s_axi_araddr == trig_pkg::ADDR_ENABLE ||
                    s_axi_araddr == trig_pkg::ADDR_STATUS || s_axi_araddr == trig_pkg::ADDR_MASK;

    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= trig_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_known ? trig_pkg::RESP_OKAY : trig_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    ctrl_reserved_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (ctrl_q & ~trig_pkg::CTRL_MASK) == 16'h0000)
        else $error("reserved control bits set");

    secondary_irq_a: assert property (@(posedge aclk) disable iff (!aresetn)
        secondary |-> !irq)
        else $error("secondary generator raised an interrupt");

    no_early_trig_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !delay_ready |=> !trigger_out)
        else $error("trigger before start delay expired");

    disable_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !enable_q |=> !delay_ready)
        else $error("delay state survived disable");

    trig_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
        enable_q && delay_ready && trigger_event && cfg.divider == 4'h0 |=> trigger_out)
        else $error("divide by one missed a trigger");

    stat_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn)
        trigger_out |-> status_q[trig_pkg::STAT_TRIG])
        else $error("trigger status not set");

    stat_start_a: assert property (@(posedge aclk) disable iff (!aresetn)
        delay_done |=> status_q[trig_pkg::STAT_START])
        else $error("start status not set");

    // Set wins, so the clear is only checked when no trigger lands in the same cycle.
    stat_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_stat && w_strb_q[0] && w_data_q[trig_pkg::STAT_TRIG] && !div_fire |=> !status_q[trig_pkg::STAT_TRIG])
        else $error("trigger status not cleared");

    irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !secondary && (status_q & mask_q) != '0 |-> irq)
        else $error("unmasked status without interrupt");

    off_no_trig_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !enable_q |=> !trigger_out)
        else $error("trigger while disabled");

    // Bus protocol: answers follow their requests and stand until they are taken.
    write_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_go |=> s_axi_bvalid)
        else $error("write response missing");

    bvalid_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");

    unmapped_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_go && !wr_known |=> s_axi_bresp == trig_pkg::RESP_SLVERR)
        else $error("unmapped write not refused");

    read_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data missing");

    rvalid_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read data dropped early");

    rd_slverr_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready && !rd_known |=> s_axi_rresp == trig_pkg::RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
        else $error("unmapped read not refused");

    ctrl_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !wr_ctrl |=> $stable(ctrl_q))
        else $error("control changed without a write");

    enable_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_en && w_strb_q[0] |=> enable_q == $past(w_data_q[0]))
        else $error("enable write lost");

    mask_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_mask && w_strb_q[0] |=> mask_q == $past(w_data_q[trig_pkg::STAT_W-1:0]))
        else $error("mask write lost");

    // Shadow tallies kept apart from the submodules, so a fault in either one shows here.
    logic [trig_pkg::DIV_W-1:0]  ev_seen_q;
    logic [trig_pkg::STRT_W-1:0] cyc_seen_q;
    wire                         ev_counted = enable_q && delay_ready && trigger_event;
    wire                         cyc_full   = &cyc_seen_q;

    always_ff @(posedge aclk) begin
        if (!aresetn || !enable_q || !delay_ready) begin
            ev_seen_q <= '0;
        end else if (ev_counted) begin
            ev_seen_q <= div_fire ? '0 : ev_seen_q + 1'b1;
        end
    end

    // The pulse tally saturates rather than wraps, so a long run cannot fake an early start.
    always_ff @(posedge aclk) begin
        if (!aresetn || !enable_q) begin
            cyc_seen_q <= '0;
        end else if (pwm_cycle && !cyc_full) begin
            cyc_seen_q <= cyc_seen_q + 1'b1;
        end
    end

    div_early_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ev_counted && ev_seen_q < cfg.divider |-> !div_fire)
        else $error("trigger passed before its divide count");

    div_due_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ev_counted && ev_seen_q >= cfg.divider |-> div_fire)
        else $error("trigger withheld at its divide count");

    delay_count_a: assert property (@(posedge aclk) disable iff (!aresetn)
        div_fire |-> cyc_seen_q >= cfg.start_delay)
        else $error("trigger passed before its start delay");
endmodule : pwm_trigger_postscaler
`default_nettype wire

// *** tb/pwm_timebase_model.sv ***
`default_nettype none
// Stand-in for the PWM time base: one cycle pulse every four clocks while running.
module pwm_timebase_model (
    // Clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // Bench controls
    input  wire logic cyc_en,
    input  wire logic ev_en,
    // Time base outputs
    output logic      pwm_cycle,
    output logic      trigger_event
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] div_q;
    // The phase restarts when stopped, so the first pulse never lands on an enable write.
    always_ff @(posedge aclk) begin
        if (!aresetn || !cyc_en) div_q <= 2'h0;
        else div_q <= div_q + 2'h1;
    end
    assign pwm_cycle     = cyc_en && (div_q == 2'h3);
    assign trigger_event = ev_en && aresetn;
endmodule : pwm_timebase_model
`default_nettype wire

// *** tb/pwm_trigger_postscaler_test.sv ***
`default_nettype none
module pwm_trigger_postscaler_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, secondary = 1'b0, cyc_en = 1'b0, ev_en = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [1:0] bresp, rresp, rs;
    logic awready, wready, bvalid, arready, rvalid, pwm_cycle, trigger_event, trigger_out, irq;
    int n_fail = 0, n_tests = 0, n_trig = 0, cycles = 0;

    pwm_timebase_model tbm (.aclk(aclk), .aresetn(aresetn), .cyc_en(cyc_en), .ev_en(ev_en),
        .pwm_cycle(pwm_cycle), .trigger_event(trigger_event));
    pwm_trigger_postscaler DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .pwm_cycle(pwm_cycle), .trigger_event(trigger_event),
        .secondary(secondary), .trigger_out(trigger_out), .irq(irq));

    initial forever #20 aclk = ~aclk;
    always @(posedge aclk) begin
        cycles++;
        if (trigger_out === 1'b1) n_trig++;
        if (cycles == 20000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish();
        if (n_fail == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : tally_and_finish

    // Both channels are offered together; each is dropped at the edge that takes it.
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] exp);
        @(posedge aclk);
        {awaddr, wdata, wstrb} <= {a, d, 4'hf};
        {awvalid, wvalid, bready} <= 3'b111;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bready && bvalid) begin
                check(bresp, exp);
                bready <= 1'b0;
            end
        end while (awvalid || wvalid || bready);
    endtask : wr

    task automatic rdr(input logic [3:0] a);
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rready && rvalid) begin
                {rd, rs} = {rdata, rresp};
                rready <= 1'b0;
            end
        end while (arvalid || rready);
    endtask : rdr

    task automatic events(input int n);
        @(posedge aclk);
        ev_en <= 1'b1;
        repeat (n) @(posedge aclk);
        ev_en <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask : events

    task automatic t_regs();
        rdr(trig_pkg::ADDR_CTRL);
        check(rd, 32'h0);
        check({irq, trigger_out}, 2'b00);
        wr(trig_pkg::ADDR_CTRL, 32'hffff_ffff, trig_pkg::RESP_OKAY);
        rdr(trig_pkg::ADDR_CTRL);
        check(rd, 32'h0000_f03f);
        wr(4'h2, 32'h1, trig_pkg::RESP_SLVERR);
        rdr(4'h2);
        check(rs, trig_pkg::RESP_SLVERR);
        check(rd, 32'h0);
    endtask : t_regs

    task automatic t_delay(input logic [5:0] d);
        int n;
        n = 0;
        wr(trig_pkg::ADDR_CTRL, {26'h0, d}, trig_pkg::RESP_OKAY);
        wr(trig_pkg::ADDR_ENABLE, 32'h1, trig_pkg::RESP_OKAY);
        {cyc_en, ev_en} <= 2'b11;
        repeat (400) begin
            @(posedge aclk);
            if (trigger_out === 1'b1) break;
            if (pwm_cycle) n++;
        end
        check(n, d);
        {cyc_en, ev_en} <= 2'b00;
        wr(trig_pkg::ADDR_ENABLE, 32'h0, trig_pkg::RESP_OKAY);
    endtask : t_delay

    task automatic t_div(input logic [3:0] v);
        wr(trig_pkg::ADDR_CTRL, {16'h0, v, 12'h0}, trig_pkg::RESP_OKAY);
        wr(trig_pkg::ADDR_ENABLE, 32'h1, trig_pkg::RESP_OKAY);
        repeat (3) @(posedge aclk);
        n_trig = 0;
        events(2 * (v + 1) + v);
        check(n_trig, 2);
        wr(trig_pkg::ADDR_ENABLE, 32'h0, trig_pkg::RESP_OKAY);
    endtask : t_div

    task automatic t_restart();
        wr(trig_pkg::ADDR_CTRL, 32'h0000_3000, trig_pkg::RESP_OKAY);
        wr(trig_pkg::ADDR_ENABLE, 32'h1, trig_pkg::RESP_OKAY);
        events(3);
        wr(trig_pkg::ADDR_ENABLE, 32'h0, trig_pkg::RESP_OKAY);
        wr(trig_pkg::ADDR_ENABLE, 32'h1, trig_pkg::RESP_OKAY);
        repeat (3) @(posedge aclk);
        n_trig = 0;
        events(3);
        check(n_trig, 0);
        events(1);
        check(n_trig, 1);
    endtask : t_restart

    task automatic t_irq();
        rdr(trig_pkg::ADDR_STATUS);
        check(rd[trig_pkg::STAT_TRIG], 1'b1);
        check(rd[trig_pkg::STAT_START], 1'b1);
        check(irq, 1'b0);
        wr(trig_pkg::ADDR_MASK, 32'h1, trig_pkg::RESP_OKAY);
        check(irq, 1'b1);
        secondary <= 1'b1;
        @(posedge aclk);
        @(posedge aclk);
        check(irq, 1'b0);
        secondary <= 1'b0;
        wr(trig_pkg::ADDR_STATUS, 32'h1, trig_pkg::RESP_OKAY);
        check(irq, 1'b0);
        rdr(trig_pkg::ADDR_STATUS);
        check(rd[trig_pkg::STAT_TRIG], 1'b0);
        check(rd[trig_pkg::STAT_START], 1'b1);
        wr(trig_pkg::ADDR_MASK, 32'h2, trig_pkg::RESP_OKAY);
        check(irq, 1'b1);
        wr(trig_pkg::ADDR_STATUS, 32'h2, trig_pkg::RESP_OKAY);
        check(irq, 1'b0);
        rdr(trig_pkg::ADDR_STATUS);
        check(rd, 32'h0000_0000);
    endtask : t_irq

    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_delay(6'h00);
        t_delay(6'h03);
        t_delay(6'h3f);
        for (int v = 0; v < 16; v++) t_div(v[3:0]);
        t_restart();
        t_irq();
        tally_and_finish();
    end
endmodule : pwm_trigger_postscaler_test
`default_nettype wire
